// ===== design/gp_pkg.sv
// Constants, types and helper functions of the eight-pin general purpose port
package gp_pkg;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int GP_NPINS = 8;
  localparam int GP_ISC_W = 2;
  localparam int GP_HALF = 4;
  localparam logic [7:0] GP_RST_DIR = 8'h00;
  localparam logic [7:0] GP_RST_OUT = 8'h00;
  localparam logic [7:0] GP_RST_PREV = 8'h00;  // Equals sync reset: no false edge after reset
  localparam logic [7:0] GP_RST_SYNC = 8'h00;

  // ----------------------------------------------------------------------
  // Driver and sense encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    GP_TOTEM = 3'h0,
    GP_BUSKEEP = 3'h1,
    GP_PULLDN = 3'h2,
    GP_PULLUP = 3'h3,
    GP_WOR = 3'h4,
    GP_WAND = 3'h5,
    GP_WOR_PD = 3'h6,
    GP_WAND_PU = 3'h7
  } gp_opc_e;

  typedef enum logic [1:0] {
    GP_BOTH = 2'h0,
    GP_RISE = 2'h1,
    GP_FALL = 2'h2,
    GP_LOW = 2'h3
  } gp_isc_e;

  // Per-pin configuration word
  typedef struct packed {
    logic inv;
    gp_opc_e opc;
    gp_isc_e isc;
  } gp_pin_cfg_s;

  localparam gp_pin_cfg_s GP_RST_CFG = '{inv: 1'b0, opc: GP_TOTEM, isc: GP_BOTH};

  // Routing of internal clocks and event to pins
  typedef struct packed {
    logic clk_en;
    logic [2:0] clk_pin;
    logic rtc_en;
    logic [2:0] rtc_pin;
    logic ev_en;
    logic [2:0] ev_pin;
  } gp_route_s;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Sense condition on current and previous sample
  function automatic logic gp_sense_hit(input gp_isc_e isc, input logic cur,
                                        input logic prv);
    unique case (isc)
      GP_BOTH: gp_sense_hit = cur ^ prv;
      GP_RISE: gp_sense_hit = cur & ~prv;
      GP_FALL: gp_sense_hit = ~cur & prv;
      GP_LOW: gp_sense_hit = ~cur;
    endcase
  endfunction : gp_sense_hit

  // Swap pin halves for the alternative peripheral location
  function automatic logic [7:0] gp_swap(input logic sel, input logic [7:0] v);
    gp_swap = sel ? {v[GP_HALF-1:0], v[7:GP_HALF]} : v;
  endfunction : gp_swap

endpackage : gp_pkg

// ===== design/gp_sync.sv
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module gp_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,           // System clock
  input wire logic rst_n_i,         // Synchronous reset, active low
  input wire logic [W-1:0] async_i, // Asynchronous input
  output logic [W-1:0] sync_o       // Synchronised output
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage read only by the second, to contain metastability
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : gp_sync

// ===== design/gp_sense.sv
// Per-pin sense condition detector
`timescale 1ns/100ps
module gp_sense (
  input wire logic clk_i,           // System clock
  input wire logic rst_n_i,         // Synchronous reset, active low
  input wire logic tick_i,          // Sample enable
  input wire logic [7:0] smp_i,     // Synchronised, inverted pin values
  input wire logic [15:0] isc_i,    // Sense selection, two bits per pin
  output logic [7:0] hit_o          // Condition seen this sample
);

  logic [7:0] prev_ff;

  // Previous sample, advanced only on a sample tick
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      prev_ff <= gp_pkg::GP_RST_PREV;
    else if (tick_i)
      prev_ff <= smp_i;
  end

  // Condition per pin
  for (genvar i = 0; i < gp_pkg::GP_NPINS; i++)
  begin : g_hit
    assign hit_o[i] = tick_i & gp_pkg::gp_sense_hit(
        gp_pkg::gp_isc_e'(isc_i[i*gp_pkg::GP_ISC_W +: gp_pkg::GP_ISC_W]),
        smp_i[i], prev_ff[i]);
  end

endmodule : gp_sense

// ===== design/gp_port.sv
// Eight-pin general purpose port: direction, drivers, sensing, routing
`timescale 1ns/100ps
module gp_port (
  input wire logic clk_i,                          // System clock, 100 MHz
  input wire logic rst_n_i,                        // Synchronous reset, active low
  input wire logic per_clk_en_i,                   // Port clock enable pulse
  input wire logic sync_clk_en_i,                  // High: synchronous sensing
  input wire logic dir_we_i,                       // Write whole direction word
  input wire logic [7:0] dir_wdata_i,              // Direction word, 1 = output
  input wire logic [7:0] dir_set_i,                // Direction set mask
  input wire logic [7:0] dir_clr_i,                // Direction clear mask
  input wire logic [7:0] dir_tgl_i,                // Direction toggle mask
  input wire logic out_we_i,                       // Write whole output word
  input wire logic [7:0] out_wdata_i,              // Output word
  input wire logic [7:0] out_set_i,                // Output set mask
  input wire logic [7:0] out_clr_i,                // Output clear mask
  input wire logic [7:0] out_tgl_i,                // Output toggle mask
  input wire logic cfg_we_i,                       // Configuration write strobe
  input wire logic [7:0] cfg_mask_i,               // Pins taking the configuration
  input wire gp_pkg::gp_pin_cfg_s cfg_wdata_i,     // Configuration word
  input wire logic [7:0] int0_mask_i,              // Pins feeding interrupt 0
  input wire logic [7:0] int1_mask_i,              // Pins feeding interrupt 1
  input wire logic [7:0] flag_clr_i,               // Sense flag clear mask
  input wire gp_pkg::gp_route_s route_i,           // Clock and event routing
  input wire logic rtc_clk_i,                      // Real-time counter clock
  input wire logic evout_i,                        // Event channel to route out
  input wire logic alt_loc_i,                      // Alternative peripheral location
  input wire logic [7:0] alt_en_i,                 // Peripheral owns pin
  input wire logic [7:0] alt_out_i,                // Peripheral output value
  input wire logic [7:0] alt_oe_i,                 // Peripheral output enable
  input wire logic [7:0] port_pin_n_i,             // Pad input levels
  output logic [7:0] port_pin_n_o,                 // Pad output levels
  output logic [7:0] port_pin_n_oe_o,              // Pad output enables, high drives
  output logic [7:0] pull_up_o,                    // Weak pull-up enables
  output logic [7:0] pull_dn_o,                    // Weak pull-down enables
  output logic [7:0] pin_in_o,                     // Sampled pin values
  output logic [7:0] dir_o,                        // Direction state
  output logic [7:0] out_o,                        // Output state
  output logic [7:0] flag_o,                       // Sticky sense flags
  output logic [7:0] event_o,                      // Sense event pulses
  output logic int0_o,                             // Port interrupt 0
  output logic int1_o,                             // Port interrupt 1
  output logic wake_o                              // Wake request
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] dir_ff;
  logic [7:0] out_ff;
  gp_pkg::gp_pin_cfg_s cfg_ff [gp_pkg::GP_NPINS];
  logic [7:0] nxt_dir;
  logic [7:0] nxt_out;
  logic [7:0] pin_s;
  logic rtc_s;
  logic [7:0] inv_vec;
  logic [15:0] isc_vec;
  logic [7:0] smp;
  logic [7:0] hit;
  logic sense_tick;
  logic [7:0] flag_ff;
  logic [7:0] event_ff;
  logic [7:0] pin_in_ff;
  logic int0_ff;
  logic int1_ff;
  logic wake_ff;
  logic clkdiv_ff;
  logic [7:0] keep_ff;
  logic [7:0] alt_en;
  logic [7:0] alt_out;
  logic [7:0] alt_oe;
  logic [7:0] nxt_pad;
  logic [7:0] nxt_oe;
  logic [7:0] nxt_pu;
  logic [7:0] nxt_pd;
  logic [7:0] pad_ff;
  logic [7:0] oe_ff;
  logic [7:0] pu_ff;
  logic [7:0] pd_ff;

  // ----------------------------------------------------------------------
  // Direction and output state
  // ----------------------------------------------------------------------
  // Whole write first, then set, clear, toggle on marked bits only
  always_comb
  begin
    nxt_dir = dir_we_i ? dir_wdata_i : dir_ff;
    nxt_dir = (nxt_dir | dir_set_i) & ~dir_clr_i;
    nxt_dir = nxt_dir ^ dir_tgl_i;
    nxt_out = out_we_i ? out_wdata_i : out_ff;
    nxt_out = (nxt_out | out_set_i) & ~out_clr_i;
    nxt_out = nxt_out ^ out_tgl_i;
  end

  // Direction and output registers for pins 0 to 7
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dir_ff <= gp_pkg::GP_RST_DIR;
      out_ff <= gp_pkg::GP_RST_OUT;
    end
    else
    begin
      dir_ff <= nxt_dir;
      out_ff <= nxt_out;
    end
  end

  // Masked configuration write, one operation for many pins
  for (genvar i = 0; i < gp_pkg::GP_NPINS; i++)
  begin : g_cfg
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        cfg_ff[i] <= gp_pkg::GP_RST_CFG;
      else if (cfg_we_i && cfg_mask_i[i])
        cfg_ff[i] <= cfg_wdata_i;
    end
    assign inv_vec[i] = cfg_ff[i].inv;
    assign isc_vec[i*gp_pkg::GP_ISC_W +: gp_pkg::GP_ISC_W] = cfg_ff[i].isc;
  end

  // ----------------------------------------------------------------------
  // Input sensing
  // ----------------------------------------------------------------------
  // Pads and real-time clock come from outside the clock domain
  gp_sync #(.W(8)) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(port_pin_n_i),
    .sync_o(pin_s)
  );

  gp_sync #(.W(1)) u_rtc_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(rtc_clk_i),
    .sync_o(rtc_s)
  );

  // Inversion ahead of sensing; port clock gates sample rate only when sensing is synchronous
  assign smp = pin_s ^ inv_vec;
  assign sense_tick = sync_clk_en_i ? per_clk_en_i : 1'b1;

  gp_sense u_sense (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(sense_tick),
    .smp_i(smp),
    .isc_i(isc_vec),
    .hit_o(hit)
  );

  // Sticky flags: a hit in the clearing cycle wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      flag_ff <= '0;
    else
      flag_ff <= (flag_ff & ~flag_clr_i) | hit;
  end

  // Events, sampled value and the two masked interrupts
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      event_ff <= '0;
      pin_in_ff <= '0;
      int0_ff <= 1'b0;
      int1_ff <= 1'b0;
    end
    else
    begin
      event_ff <= hit;
      pin_in_ff <= smp;
      int0_ff <= |(flag_ff & int0_mask_i);
      int1_ff <= |(flag_ff & int1_mask_i);
    end
  end

  // Wake needs no port clock; it fires only while sensing is asynchronous (sync_clk_en_i low)
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      wake_ff <= 1'b0;
    else
      wake_ff <= !sync_clk_en_i && |(hit & (int0_mask_i | int1_mask_i));
  end

  // ----------------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------------
  // Routed clock toggles on each port clock pulse, running at half the port clock rate
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      clkdiv_ff <= 1'b0;
    else if (per_clk_en_i)
      clkdiv_ff <= ~clkdiv_ff;
  end

  // Keeper remembers the last level seen on the pad
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      keep_ff <= '0;
    else
      keep_ff <= pin_s;
  end

  // Peripheral functions at default or alternative location
  assign alt_en = gp_pkg::gp_swap(alt_loc_i, alt_en_i);
  assign alt_out = gp_pkg::gp_swap(alt_loc_i, alt_out_i);
  assign alt_oe = gp_pkg::gp_swap(alt_loc_i, alt_oe_i);

  for (genvar i = 0; i < gp_pkg::GP_NPINS; i++)
  begin : g_pad
    logic val;
    logic drv;
    logic wired;
    always_comb
    begin
      val = out_ff[i];
      drv = dir_ff[i];
      // Routed signals take the pin as an output
      if (route_i.ev_en && route_i.ev_pin == 3'(i))
      begin
        val = evout_i;
        drv = 1'b1;
      end
      if (route_i.rtc_en && route_i.rtc_pin == 3'(i))
      begin
        val = rtc_s;
        drv = 1'b1;
      end
      if (route_i.clk_en && route_i.clk_pin == 3'(i))
      begin
        val = clkdiv_ff;
        drv = 1'b1;
      end
      // An enabled peripheral overrides the output word and routed signals; inversion and driver mode still apply
      if (alt_en[i])
      begin
        val = alt_out[i];
        drv = alt_oe[i];
      end
      val = val ^ cfg_ff[i].inv;
      wired = 1'b0;
      nxt_pad[i] = val;
      nxt_oe[i] = drv;
      nxt_pu[i] = 1'b0;
      nxt_pd[i] = 1'b0;
      unique case (cfg_ff[i].opc)
        gp_pkg::GP_TOTEM: wired = 1'b0;
        gp_pkg::GP_BUSKEEP:
        begin
          nxt_pu[i] = !drv && keep_ff[i];
          nxt_pd[i] = !drv && !keep_ff[i];
        end
        gp_pkg::GP_PULLDN: nxt_pd[i] = !drv;
        gp_pkg::GP_PULLUP: nxt_pu[i] = !drv;
        gp_pkg::GP_WOR: wired = 1'b1;
        gp_pkg::GP_WAND: wired = 1'b1;
        gp_pkg::GP_WOR_PD:
        begin
          wired = 1'b1;
          nxt_pd[i] = 1'b1;
        end
        gp_pkg::GP_WAND_PU:
        begin
          wired = 1'b1;
          nxt_pu[i] = 1'b1;
        end
      endcase
      // Wired-OR drives only ones, wired-AND only zeros
      if (wired)
        nxt_oe[i] = drv && (cfg_ff[i].opc[0] ? !val : val);
    end
  end

  // Pad outputs registered so glitches never reach the pins
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pad_ff <= '0;
      oe_ff <= '0;
      pu_ff <= '0;
      pd_ff <= '0;
    end
    else
    begin
      pad_ff <= nxt_pad;
      oe_ff <= nxt_oe;
      pu_ff <= nxt_pu;
      pd_ff <= nxt_pd;
    end
  end

  assign port_pin_n_o = pad_ff;
  assign port_pin_n_oe_o = oe_ff;
  assign pull_up_o = pu_ff;
  assign pull_dn_o = pd_ff;
  assign pin_in_o = pin_in_ff;
  assign dir_o = dir_ff;
  assign out_o = out_ff;
  assign flag_o = flag_ff;
  assign event_o = event_ff;
  assign int0_o = int0_ff;
  assign int1_o = int1_ff;
  assign wake_o = wake_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_dir_set;
    (!dir_we_i && dir_clr_i == 8'h00 && dir_tgl_i == 8'h00) |=>
      dir_ff == ($past(dir_ff) | $past(dir_set_i));
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("direction set failed");

  property p_out_tgl;
    (!out_we_i && out_set_i == 8'h00 && out_clr_i == 8'h00) |=>
      out_ff == ($past(out_ff) ^ $past(out_tgl_i));
  endproperty
  a_out_tgl: assert property (p_out_tgl) else $error("output toggle failed");

  property p_cfg_mask;
    (cfg_we_i && cfg_mask_i[0]) |=> cfg_ff[0] == $past(cfg_wdata_i);
  endproperty
  a_cfg_mask: assert property (p_cfg_mask) else $error("masked cfg lost");

  property p_flag_set;
    (hit != 8'h00) |=> (flag_o & $past(hit)) == $past(hit);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("sense flag lost");

  property p_sync_tick;
    (sync_clk_en_i && !per_clk_en_i) |-> hit == 8'h00;
  endproperty
  a_sync_tick: assert property (p_sync_tick) else $error("sense off tick");

  property p_wake;
    (!sync_clk_en_i && (hit & int0_mask_i) != 8'h00) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");

  property p_int0;
    (flag_ff & int0_mask_i) != 8'h00 |=> int0_o;
  endproperty
  a_int0: assert property (p_int0) else $error("interrupt 0 missing");

  property p_int1_mask;
    (flag_ff & int1_mask_i) == 8'h00 |=> !int1_o;
  endproperty
  a_int1_mask: assert property (p_int1_mask) else $error("interrupt 1 unmasked");

  property p_keeper;
    (cfg_ff[7].opc == gp_pkg::GP_BUSKEEP && !nxt_oe[7] && keep_ff[7]) |=>
      pull_up_o[7] && !pull_dn_o[7];
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper level wrong");

  property p_wand;
    (cfg_ff[0].opc == gp_pkg::GP_WAND && nxt_pad[0]) |=> !port_pin_n_oe_o[0];
  endproperty
  a_wand: assert property (p_wand) else $error("wired-AND drove one");

  c_hit: cover property (hit != 8'h00 ##1 int0_o);
  c_wake: cover property (!sync_clk_en_i ##1 wake_o);
  c_alt: cover property (alt_en_i[0] && alt_loc_i);
  c_keep: cover property (pull_up_o[7] ##1 pull_dn_o[7]);

endmodule : gp_port

// ===== testbench/gp_pad_model.sv
// Pad model: resolves each pin from port drive, outside driver and weak pulls
`timescale 1ns/100ps
module gp_pad_model (
  input wire logic clk_i,           // System clock
  input wire logic [7:0] drv_i,     // Port drive value
  input wire logic [7:0] oe_i,      // Port drive enable
  input wire logic [7:0] pu_i,      // Weak pull-up
  input wire logic [7:0] pd_i,      // Weak pull-down
  input wire logic [7:0] ext_en_i,  // Outside driver active
  input wire logic [7:0] ext_val_i, // Outside driven level
  output logic [7:0] pad_o          // Resolved pad level
);
  // ----------------------------------------------------------------------
  // Resolution
  // ----------------------------------------------------------------------
  logic [7:0] last_ff = 8'h00;
  // A floating pin shows the inverse of its last level, so no stale value passes
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pad_o[i] = oe_i[i] ? drv_i[i] : ext_en_i[i] ? ext_val_i[i] :
                 pu_i[i] ? 1'h1 : pd_i[i] ? 1'h0 : ~last_ff[i];
    end
  end
  // Last level memory
  always_ff @(posedge clk_i)
  begin
    last_ff <= pad_o;
  end
endmodule : gp_pad_model

// ===== testbench/gp_port_tb.sv
// Self-checking bench for the eight-pin general purpose port
`timescale 1ns/100ps
module gp_port_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic pce = 1'h0, sce = 1'h0, dwe = 1'h0, owe = 1'h0, cwe = 1'h0;
  logic rtc = 1'h0, evo = 1'h0, aloc = 1'h0;
  logic [7:0] dwd = 8'h00, ds = 8'h00, dc = 8'h00, dt = 8'h00, owd = 8'h00;
  logic [7:0] os = 8'h00, oc = 8'h00, ot = 8'h00, cm = 8'h00, m0 = 8'h00, m1 = 8'h00;
  logic [7:0] fc = 8'h00, aen = 8'h00, aout = 8'h00, aoe = 8'h00, xen = 8'hff, xv = 8'h00;
  gp_pkg::gp_pin_cfg_s cw = gp_pkg::GP_RST_CFG;
  gp_pkg::gp_route_s rt = 12'h000;
  logic [7:0] pad, po, poe, pu, pd, pin, dir, out, flg, ev;
  logic i0, i1, wk;
  int err_total = 0;
  int n_checks = 0;

  // Clock, 100 MHz
  always #5 clk_i = ~clk_i;

  gp_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .per_clk_en_i(pce), .sync_clk_en_i(sce),
    .dir_we_i(dwe), .dir_wdata_i(dwd), .dir_set_i(ds), .dir_clr_i(dc), .dir_tgl_i(dt),
    .out_we_i(owe), .out_wdata_i(owd), .out_set_i(os), .out_clr_i(oc), .out_tgl_i(ot),
    .cfg_we_i(cwe), .cfg_mask_i(cm), .cfg_wdata_i(cw), .int0_mask_i(m0), .int1_mask_i(m1),
    .flag_clr_i(fc), .route_i(rt), .rtc_clk_i(rtc), .evout_i(evo), .alt_loc_i(aloc),
    .alt_en_i(aen), .alt_out_i(aout), .alt_oe_i(aoe), .port_pin_n_i(pad),
    .port_pin_n_o(po), .port_pin_n_oe_o(poe), .pull_up_o(pu), .pull_dn_o(pd),
    .pin_in_o(pin), .dir_o(dir), .out_o(out), .flag_o(flg), .event_o(ev),
    .int0_o(i0), .int1_o(i1), .wake_o(wk));

  gp_pad_model pads (.clk_i(clk_i), .drv_i(po), .oe_i(poe), .pu_i(pu), .pd_i(pd),
    .ext_en_i(xen), .ext_val_i(xv), .pad_o(pad));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Inputs move 1 ns after the edge, away from sampling
  task automatic step(input int n = 1);
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
    end
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic [7:0] m, input logic v, input gp_pkg::gp_opc_e o,
                     input gp_pkg::gp_isc_e s);
    cm = m;
    cw = '{inv: v, opc: o, isc: s};
    cwe = 1'h1;
    step();
    cwe = 1'h0;
    step(2);
  endtask : cfg

  task automatic dir_out(input logic [7:0] d, input logic [7:0] o);
    dwd = d;
    owd = o;
    dwe = 1'h1;
    owe = 1'h1;
    step();
    dwe = 1'h0;
    owe = 1'h0;
    step(2);
  endtask : dir_out

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Direction changes touch only the marked pins
  task automatic t_dir();
    dir_out(8'h0f, 8'h00);
    chk(dir, 8'h0f);
    ds = 8'h80;
    step();
    ds = 8'h00;
    step();
    chk(dir, 8'h8f);
    dc = 8'h01;
    step();
    dc = 8'h00;
    step();
    chk(dir, 8'h8e);
    dt = 8'h03;
    step();
    dt = 8'h00;
    step();
    chk(dir, 8'h8d);
  endtask : t_dir

  // Set, clear and toggle of the output word, seen at the pads
  task automatic t_out();
    dir_out(8'hff, 8'h5a);
    chk(out, 8'h5a);
    os = 8'h01;
    step();
    os = 8'h00;
    oc = 8'h40;
    step();
    oc = 8'h00;
    ot = 8'hff;
    step();
    ot = 8'h00;
    step(2);
    chk(out, 8'he4);
    chk(po, 8'he4);
    chk(poe, 8'hff);
  endtask : t_out

  // Masked configuration, pulls and wired drivers
  task automatic t_cfg();
    dir_out(8'h00, 8'h0f);
    cfg(8'h0f, 1'h0, gp_pkg::GP_PULLUP, gp_pkg::GP_BOTH);
    cfg(8'hf0, 1'h0, gp_pkg::GP_PULLDN, gp_pkg::GP_BOTH);
    chk(pu, 8'h0f);
    chk(pd, 8'hf0);
    dir_out(8'hff, 8'h0f);
    cfg(8'hff, 1'h0, gp_pkg::GP_WAND, gp_pkg::GP_BOTH);
    chk(poe, 8'hf0);
    cfg(8'hff, 1'h0, gp_pkg::GP_WOR, gp_pkg::GP_BOTH);
    chk(poe, 8'h0f);
    cfg(8'hff, 1'h0, gp_pkg::GP_WAND_PU, gp_pkg::GP_BOTH);
    chk(pu, 8'hff);
    cfg(8'hff, 1'h0, gp_pkg::GP_WOR_PD, gp_pkg::GP_BOTH);
    chk(pd, 8'hff);
    chk(poe, 8'h0f);
    cfg(8'hff, 1'h0, gp_pkg::GP_TOTEM, gp_pkg::GP_BOTH);
    dir_out(8'h00, 8'h00);
  endtask : t_cfg

  // One sense condition on one pin; a missed event counts as a mismatch
  task automatic sense_case(input int p, input gp_pkg::gp_isc_e s, input logic v,
                            input logic l, input logic e);
    logic seen;
    seen = 1'h0;
    xv[p] = ~l;
    cfg(8'h01 << p, v, gp_pkg::GP_TOTEM, s);
    step(4);
    fc = 8'hff;
    step();
    fc = 8'h00;
    step(2);
    xv[p] = l;
    for (int k = 0; k < 8; k++)
    begin
      step();
      if (ev[p] === 1'h1 && !seen)
      begin
        seen = 1'h1;
        chk({7'h00, k >= 2}, 8'h01);
        chk({7'h00, wk}, 8'h01);
        chk(flg & (8'h01 << p), 8'h01 << p);
        step();
        chk({6'h00, i1, i0}, 8'h01);
      end
    end
    chk({7'h00, seen}, {7'h00, e});
  endtask : sense_case

  task automatic t_sense();
    m0 = 8'hff;
    sense_case(0, gp_pkg::GP_RISE, 1'h0, 1'h1, 1'h1);
    sense_case(1, gp_pkg::GP_FALL, 1'h1, 1'h1, 1'h1);
    sense_case(2, gp_pkg::GP_FALL, 1'h0, 1'h1, 1'h0);
    sense_case(3, gp_pkg::GP_BOTH, 1'h0, 1'h1, 1'h1);
    sense_case(4, gp_pkg::GP_LOW, 1'h0, 1'h0, 1'h1);
    chk(pin & 8'h02, 8'h00);
    m0 = 8'h00;
    m1 = 8'hff;
    step(3);
    chk({6'h00, i1, i0}, 8'h02);
    m1 = 8'h00;
  endtask : t_sense

  // Synchronous sensing waits for the port clock tick
  task automatic t_sync();
    sce = 1'h1;
    cfg(8'h20, 1'h0, gp_pkg::GP_TOTEM, gp_pkg::GP_RISE);
    fc = 8'hff;
    step();
    fc = 8'h00;
    xv[5] = 1'h1;
    step(8);
    chk(flg & 8'h20, 8'h00);
    pce = 1'h1;
    step();
    pce = 1'h0;
    step(3);
    chk(flg & 8'h20, 8'h20);
    sce = 1'h0;
  endtask : t_sync

  // Keeper follows the last pad level and holds it when released
  task automatic t_keep();
    cfg(8'h80, 1'h0, gp_pkg::GP_BUSKEEP, gp_pkg::GP_BOTH);
    xv[7] = 1'h1;
    step(5);
    chk({pu[7], pd[7]}, 8'h02);
    xv[7] = 1'h0;
    step(5);
    xen[7] = 1'h0;
    step(5);
    chk({pu[7], pd[7]}, 8'h01);
    xen[7] = 1'h1;
  endtask : t_keep

  // Peripheral override, remap, inversion and routed signals
  task automatic t_alt();
    logic a;
    cfg(8'hff, 1'h0, gp_pkg::GP_TOTEM, gp_pkg::GP_BOTH);
    dir_out(8'hff, 8'h00);
    aen = 8'h01;
    aout = 8'h01;
    aoe = 8'h01;
    step(3);
    chk(po, 8'h01);
    aloc = 1'h1;
    step(3);
    chk(po, 8'h10);
    aloc = 1'h0;
    aen = 8'h00;
    cfg(8'h01, 1'h1, gp_pkg::GP_TOTEM, gp_pkg::GP_BOTH);
    chk(po, 8'h01);
    rt = '{clk_en: 1'h1, clk_pin: 3'h3, rtc_en: 1'h1, rtc_pin: 3'h5,
           ev_en: 1'h1, ev_pin: 3'h2};
    evo = 1'h1;
    rtc = 1'h1;
    step(5);
    chk(po & 8'h24, 8'h24);
    evo = 1'h0;
    rtc = 1'h0;
    step(5);
    chk(po & 8'h24, 8'h00);
    a = po[3];
    pce = 1'h1;
    step();
    pce = 1'h0;
    step(3);
    chk({7'h00, po[3]}, {7'h00, ~a});
  endtask : t_alt

  // ----------------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Two edges of reset clear both synchroniser stages
  initial
  begin
    step(2);
    rst_n_i = 1'h1;
    step();
    chk(dir | out | poe | flg, 8'h00);
    t_dir();
    t_out();
    t_cfg();
    t_sense();
    t_sync();
    t_keep();
    t_alt();
    tally_and_finish();
  end
endmodule : gp_port_tb
